// [pesc_event_counters.sv]
// Event status, enables and statistics counters of the transceiver management block
`timescale 1ns/10ps
`include "pesc_regs.svh"

module pesc_event_counters
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Management register access
  input  wire pesc_pkg::pesc_req_s req,
  output logic [15:0]             rdata_ff,
  // Transceiver events
  input  wire pesc_pkg::pesc_evt_s evt,
  // Interrupt request level
  output logic                    irq
);

  logic [6:0]  pend_ff;
  logic [6:0]  en_ff;
  logic [1:0]  mctl_ff;
  logic [7:0]  fc_cnt_ff;
  logic [7:0]  rx_cnt_ff;
  logic        coll_ff;
  pesc_pkg::pesc_rx_e rx_st_ff;
  logic        rd_event;
  logic        rd_fc;
  logic        rd_rx;
  logic        fc_half;
  logic        rx_half;
  logic        rx_hit;
  logic [6:0]  evt_vec;
  logic [15:0] nxt_rdata;

  // Read strobes per register
  assign rd_event = req.rd && (req.addr == `PESC_ADDR_EVENT);
  assign rd_fc    = req.rd && (req.addr == `PESC_ADDR_FALSE_CNT);
  assign rd_rx    = req.rd && (req.addr == `PESC_ADDR_RXERR_CNT);

  // Half-full edge: bit 7 rises only once per clear, as counters stick at max
  assign fc_half = evt.false_carrier && !fc_cnt_ff[`PESC_CNT_HALF_BIT]
                   && (fc_cnt_ff == 8'h7F) && !rd_fc;
  assign rx_half = rx_hit && (rx_cnt_ff == 8'h7F) && !rd_rx;

  // Event vector in pending bit order, 14 down to 8
  assign evt_vec = {evt.energy, evt.link_change, evt.speed_change, evt.duplex_change,
                    evt.neg_done, fc_half, rx_half};

  // Pending flags: read clears, a same-cycle event wins so nothing is lost
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pend_ff <= 7'h00;
    else
      pend_ff <= (rd_event ? 7'h00 : pend_ff) | evt_vec;
  end

  // Enables and master control; reserved bits are simply not stored
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_ff   <= 7'h00;
      mctl_ff <= 2'h0;
    end
    else if (req.wr && req.addr == `PESC_ADDR_EVENT)
      en_ff <= req.wdata[`PESC_EN_MSB:`PESC_EN_LSB];
    else if (req.wr && req.addr == `PESC_ADDR_MASTER_CTL)
      mctl_ff <= req.wdata[`PESC_MCTL_TEST_INTERRUPT_FORCE:`PESC_MCTL_MASTER_EVENT_ENABLE];
  end

  // False carrier counter, sticks at max, read clears; an event on the read cycle counts from zero
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      fc_cnt_ff <= 8'h00;
    else if (rd_fc)
      fc_cnt_ff <= {7'h00, evt.false_carrier};
    else if (evt.false_carrier && fc_cnt_ff != `PESC_CNT_MAX)
      fc_cnt_ff <= fc_cnt_ff + 8'h01;
  end

  // Carrier tracking: one count per carrier event with a bad symbol, none once a collision has been seen in that carrier
  assign rx_hit = evt.carrier && evt.bad_symbol && !evt.collision && !coll_ff
                  && (rx_st_ff != pesc_pkg::PESC_COUNTED);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_ff <= pesc_pkg::PESC_IDLE;
      coll_ff  <= 1'b0;
    end
    else if (!evt.carrier)
    begin
      rx_st_ff <= pesc_pkg::PESC_IDLE;
      coll_ff  <= 1'b0;
    end
    else
    begin
      coll_ff <= coll_ff | evt.collision;
      unique case (rx_st_ff)
        pesc_pkg::PESC_IDLE,
        pesc_pkg::PESC_CARRIER: rx_st_ff <= rx_hit ? pesc_pkg::PESC_COUNTED : pesc_pkg::PESC_CARRIER;
        pesc_pkg::PESC_COUNTED: rx_st_ff <= pesc_pkg::PESC_COUNTED;
        default:                rx_st_ff <= pesc_pkg::PESC_IDLE;
      endcase
    end
  end

  // Receive error counter, sticks at max until read
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rx_cnt_ff <= 8'h00;
    else if (rd_rx)
      rx_cnt_ff <= {7'h00, rx_hit};
    else if (rx_hit && rx_cnt_ff != `PESC_CNT_MAX)
      rx_cnt_ff <= rx_cnt_ff + 8'h01;
  end

  // Read mux; reserved fields are zero
  always_comb
  begin
    nxt_rdata = `PESC_RESET_VALUE;
    unique case (req.addr)
      `PESC_ADDR_EVENT:      nxt_rdata = {1'b0, pend_ff, 1'b0, en_ff};
      `PESC_ADDR_FALSE_CNT:  nxt_rdata = {8'h00, fc_cnt_ff};
      `PESC_ADDR_RXERR_CNT:  nxt_rdata = {8'h00, rx_cnt_ff};
      `PESC_ADDR_MASTER_CTL: nxt_rdata = {13'h0000, mctl_ff, 1'b0};
      default:               nxt_rdata = `PESC_RESET_VALUE;
    endcase
  end

  // Read data is captured with the old value, so a clear-on-read reports first
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= `PESC_RESET_VALUE;
    else if (req.rd)
      rdata_ff <= nxt_rdata;
  end

  // Level interrupt: enabled pending flags under master enable, or test force
  assign irq = (mctl_ff[1]) | (mctl_ff[0] && |(pend_ff & en_ff));

  // Checks
  property p_pend_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_event && evt_vec == 7'h00 |=> pend_ff == 7'h00;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared by read");

  property p_pend_set;
    @(posedge clk_sys) disable iff (!rst_n)
      evt.link_change |=> pend_ff[5];
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("link pending not set");

  property p_read_reports;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_event |=> rdata_ff[14:8] == $past(pend_ff);
  endproperty
  a_read_reports: assert property (p_read_reports) else $error("read lost pending value");

  property p_reserved;
    @(posedge clk_sys) disable iff (!rst_n)
      $past(rd_event) |-> rdata_ff[15] == 1'b0 && rdata_ff[7] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit nonzero");

  property p_fc_inc;
    @(posedge clk_sys) disable iff (!rst_n)
      evt.false_carrier && !rd_fc && fc_cnt_ff != 8'hFF |=> fc_cnt_ff == $past(fc_cnt_ff) + 8'h01;
  endproperty
  a_fc_inc: assert property (p_fc_inc) else $error("false carrier count wrong");

  property p_fc_stick;
    @(posedge clk_sys) disable iff (!rst_n)
      fc_cnt_ff == 8'hFF && !rd_fc |=> fc_cnt_ff == 8'hFF;
  endproperty
  a_fc_stick: assert property (p_fc_stick) else $error("false carrier counter wrapped");

  property p_fc_clr;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_fc && !evt.false_carrier |=> fc_cnt_ff == 8'h00;
  endproperty
  a_fc_clr: assert property (p_fc_clr) else $error("false carrier not cleared");

  sequence s_counted;
    rx_hit ##1 evt.carrier [*2];
  endsequence
  property p_once;
    @(posedge clk_sys) disable iff (!rst_n)
      s_counted |-> !rx_hit;
  endproperty
  a_once: assert property (p_once) else $error("counted twice in one carrier");

  property p_coll;
    @(posedge clk_sys) disable iff (!rst_n)
      evt.collision && !rd_rx |=> rx_cnt_ff == $past(rx_cnt_ff);
  endproperty
  a_coll: assert property (p_coll) else $error("counted during collision");

  property p_half;
    @(posedge clk_sys) disable iff (!rst_n)
      !rd_event && $rose(fc_cnt_ff[7]) |-> pend_ff[1];
  endproperty
  a_half: assert property (p_half) else $error("half-full pending missed");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
      irq |-> mctl_ff[1] || (mctl_ff[0] && (pend_ff & en_ff) != 7'h00);
  endproperty
  a_irq: assert property (p_irq) else $error("spurious interrupt");

  // Each status source lands in its own pending bit, whatever its enable says
  property p_energy_set;
    @(posedge clk_sys) disable iff (!rst_n)
      evt.energy |=> pend_ff[6];
  endproperty
  a_energy_set: assert property (p_energy_set) else $error("energy pending not set");

  property p_speed_set;
    @(posedge clk_sys) disable iff (!rst_n)
      evt.speed_change |=> pend_ff[4];
  endproperty
  a_speed_set: assert property (p_speed_set) else $error("speed pending not set");

  property p_duplex_set;
    @(posedge clk_sys) disable iff (!rst_n)
      evt.duplex_change |=> pend_ff[3];
  endproperty
  a_duplex_set: assert property (p_duplex_set) else $error("duplex pending not set");

  property p_neg_set;
    @(posedge clk_sys) disable iff (!rst_n)
      evt.neg_done |=> pend_ff[2];
  endproperty
  a_neg_set: assert property (p_neg_set) else $error("negotiation pending not set");

  property p_rx_half;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(rx_cnt_ff[7]) |-> pend_ff[0];
  endproperty
  a_rx_half: assert property (p_rx_half) else $error("receive half-full pending missed");

  // Enables change only through a write to the event register
  property p_en_write;
    @(posedge clk_sys) disable iff (!rst_n)
      req.wr && req.addr == `PESC_ADDR_EVENT |=> en_ff == $past(req.wdata[6:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");

  property p_en_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !(req.wr && req.addr == `PESC_ADDR_EVENT) |=> $stable(en_ff);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enables changed without write");

  property p_cnt_rsvd;
    @(posedge clk_sys) disable iff (!rst_n)
      $past(rd_fc || rd_rx) |-> rdata_ff[15:8] == 8'h00;
  endproperty
  a_cnt_rsvd: assert property (p_cnt_rsvd) else $error("counter upper byte nonzero");

  // Counter checks; a read racing an event must not lose that event
  property p_fc_rd_event;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_fc && evt.false_carrier |=> fc_cnt_ff == 8'h01;
  endproperty
  a_fc_rd_event: assert property (p_fc_rd_event) else $error("event lost on counter read");

  property p_rx_inc;
    @(posedge clk_sys) disable iff (!rst_n)
      rx_hit && !rd_rx && rx_cnt_ff != 8'hFF |=> rx_cnt_ff == $past(rx_cnt_ff) + 8'h01;
  endproperty
  a_rx_inc: assert property (p_rx_inc) else $error("receive error count wrong");

  property p_rx_bad_only;
    @(posedge clk_sys) disable iff (!rst_n)
      !(evt.carrier && evt.bad_symbol) && !rd_rx |=> $stable(rx_cnt_ff);
  endproperty
  a_rx_bad_only: assert property (p_rx_bad_only) else $error("receive error counted without bad symbol");

  property p_rx_clr;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_rx && !rx_hit |=> rx_cnt_ff == 8'h00;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("receive error not cleared");

  property p_rx_stick;
    @(posedge clk_sys) disable iff (!rst_n)
      rx_cnt_ff == `PESC_CNT_MAX && !rd_rx |=> rx_cnt_ff == `PESC_CNT_MAX;
  endproperty
  a_rx_stick: assert property (p_rx_stick) else $error("receive error counter wrapped");

  // A collision in a carrier blocks a count in the next cycle of that carrier
  sequence s_coll_seen;
    (evt.carrier && evt.collision) ##1 evt.carrier;
  endsequence
  property p_coll_later;
    @(posedge clk_sys) disable iff (!rst_n)
      s_coll_seen |-> !rx_hit;
  endproperty
  a_coll_later: assert property (p_coll_later) else $error("counted after collision");

  property p_no_master;
    @(posedge clk_sys) disable iff (!rst_n)
      !mctl_ff[0] && !mctl_ff[1] |-> !irq;
  endproperty
  a_no_master: assert property (p_no_master) else $error("interrupt without master enable");

endmodule

// [pesc_event_counters_test.sv]
// Self-checking bench for the event status and counter block
`timescale 1ns/10ps

module pesc_event_counters_test;
  logic                clk_sys;
  logic                rst_n;
  pesc_pkg::pesc_req_s req;
  pesc_pkg::pesc_evt_s evt;
  logic [15:0]         rdata_ff;
  logic                irq;
  int                  failures = 0;
  int                  n_tests = 0;
  int                  cycles = 0;

  pesc_event_counters i_pesc_event_counters (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata_ff(rdata_ff),
                                             .evt(evt), .irq(irq));
  pesc_mgmt_model i_pesc_mgmt_model (.clk_sys(clk_sys), .req(req), .rdata_ff(rdata_ff));

  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] q;
    i_pesc_mgmt_model.acc(1'b0, a, 16'h0000, q);
    check($sformatf("reg %h", a), q, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    i_pesc_mgmt_model.acc(1'b1, a, d, q);
  endtask

  // Event inputs held for n cycles, then a quiet cycle so carriers are separate
  task automatic drive(input logic [8:0] v, input int n);
    @(negedge clk_sys);
    evt = v;
    repeat (n) @(negedge clk_sys);
    evt = '0;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Clock at 100 ns
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    evt = '0;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    // Reset values, unmapped place, reserved bits
    rd(5'h12, 16'h0000);
    rd(5'h14, 16'h0000);
    rd(5'h15, 16'h0000);
    rd(5'h1F, 16'h0000);
    wr(5'h12, 16'hFFFF);
    rd(5'h12, 16'h007F);
    wr(5'h14, 16'hFFFF);
    rd(5'h14, 16'h0000);
    wr(5'h12, 16'h0000);
    $display("done: registers");
    // Each status source with its enable off, set then cleared by the read
    for (int i = 0; i < 5; i++)
    begin
      drive(9'h100 >> i, 1);
      rd(5'h12, 16'h4000 >> i);
      rd(5'h12, 16'h0000);
    end
    $display("done: status flags");
    // False carrier count, half-full, clear on read, saturation
    repeat (128) drive(9'h008, 1);
    rd(5'h14, 16'h0080);
    rd(5'h12, 16'h0200);
    rd(5'h14, 16'h0000);
    repeat (260) drive(9'h008, 1);
    rd(5'h14, 16'h00FF);
    rd(5'h12, 16'h0200);
    $display("done: false carrier");
    // Receive errors: once per carrier, none with collision
    drive(9'h006, 3);
    drive(9'h007, 3);
    drive(9'h004, 2);
    // Collision in the first cycle of a carrier, bad symbols later in the same carrier
    @(negedge clk_sys);
    evt = 9'h005;
    drive(9'h006, 2);
    rd(5'h15, 16'h0001);
    repeat (128) drive(9'h006, 2);
    rd(5'h15, 16'h0080);
    rd(5'h12, 16'h0100);
    repeat (260) drive(9'h006, 2);
    rd(5'h15, 16'h00FF);
    rd(5'h15, 16'h0000);
    rd(5'h12, 16'h0100);
    $display("done: receive errors");
    // Interrupt gating by enable and master bit, and the test force
    wr(5'h12, 16'h0040);
    wr(5'h11, 16'h0002);
    drive(9'h100, 1);
    check("irq", {15'h0, irq}, 16'h0001);
    rd(5'h12, 16'h4040);
    check("irq", {15'h0, irq}, 16'h0000);
    wr(5'h11, 16'h0000);
    drive(9'h100, 1);
    check("irq", {15'h0, irq}, 16'h0000);
    rd(5'h12, 16'h4040);
    wr(5'h11, 16'h0002);
    wr(5'h12, 16'h0000);
    drive(9'h100, 1);
    check("irq", {15'h0, irq}, 16'h0000);
    rd(5'h12, 16'h4000);
    wr(5'h11, 16'h0004);
    repeat (3) @(negedge clk_sys);
    check("irq", {15'h0, irq}, 16'h0001);
    rd(5'h11, 16'h0004);
    $display("done: interrupt");
    // Reset in mid-run clears the false carrier counter, enables and master control
    drive(9'h008, 1);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    check("irq", {15'h0, irq}, 16'h0000);
    rd(5'h14, 16'h0000);
    rd(5'h12, 16'h0000);
    rd(5'h11, 16'h0000);
    // Events in the same cycle as the read that clears them
    fork
      rd(5'h14, 16'h0000);
      drive(9'h008, 1);
    join
    rd(5'h14, 16'h0001);
    fork
      rd(5'h12, 16'h0000);
      drive(9'h100, 1);
    join
    rd(5'h12, 16'h4000);
    $display("done: reset and same-cycle events");
    give_verdict();
  end
endmodule

// [pesc_mgmt_model.sv]
// Management station model that makes register reads and writes
`timescale 1ns/10ps

module pesc_mgmt_model
(
  // Clock
  input  wire logic          clk_sys,
  // Register access
  output pesc_pkg::pesc_req_s req,
  input  wire logic [15:0]   rdata_ff
);
  initial req = '0;

  // One access per call, strobe held across exactly one rising edge, answer taken one edge later
  task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge clk_sys);
    req = '{rd: !wr, wr: wr, addr: a, wdata: d};
    @(negedge clk_sys);
    q = rdata_ff;
    req = '0;
  endtask
endmodule

// [pesc_pkg.sv]
// Types shared by the event status and counter block
package pesc_pkg;
  // Management register access, one per cycle
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pesc_req_s;
  // Raw event inputs from the transceiver core
  typedef struct packed {
    logic energy;
    logic link_change;
    logic speed_change;
    logic duplex_change;
    logic neg_done;
    logic false_carrier;
    logic carrier;
    logic bad_symbol;
    logic collision;
  } pesc_evt_s;
  // Receive error tracking state within a carrier event
  typedef enum logic [1:0] {
    PESC_IDLE    = 2'b00,
    PESC_CARRIER = 2'b01,
    PESC_COUNTED = 2'b11
  } pesc_rx_e;
endpackage

// [pesc_regs.svh]
// Register offsets, field positions and reset values of the event status and counter block
`ifndef PESC_REGS_SVH
`define PESC_REGS_SVH
`define PESC_ADDR_EVENT       5'h12
`define PESC_ADDR_FALSE_CNT   5'h14
`define PESC_ADDR_RXERR_CNT   5'h15
`define PESC_ADDR_MASTER_CTL  5'h11
`define PESC_PEND_LSB         8
`define PESC_PEND_MSB         14
`define PESC_EN_LSB           0
`define PESC_EN_MSB           6
`define PESC_MCTL_MASTER_EVENT_ENABLE       1
`define PESC_MCTL_TEST_INTERRUPT_FORCE        2
`define PESC_CNT_MAX          8'hFF
`define PESC_CNT_HALF_BIT     7
`define PESC_RESET_VALUE      16'h0000
`endif
